//--- include/sbsp_pkg.sv
package sbsp_pkg;

  // ----------------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------------
  localparam int ADDR_W_DFLT = 19;   // 512k words of 36 bits
  localparam int DATA_W_DFLT = 36;   // 18 for the 1m word organisation
  localparam int LANE_W      = 9;    // eight data bits plus a parity bit
  localparam int BURST_W     = 2;
  localparam int CLK_MHZ     = 100;
  localparam int BUS_MHZ_MAX = 133;  // fastest supported bus rate

  // ----------------------------------------------------------------------
  // reset values and counter step
  // ----------------------------------------------------------------------
  localparam logic [BURST_W-1:0] BEAT_RST  = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;
  localparam logic               SYNC_RST  = 1'h0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic {sbsp_linear, sbsp_interleaved} sbsp_order_t;
  typedef enum logic [1:0] {sbsp_idle, sbsp_burst} sbsp_state_t;

  // low address bits of a beat, from start bits and beat count
  function automatic logic [BURST_W-1:0] sbsp_beat_addr(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count,
    input sbsp_order_t        order
  );
    if (order == sbsp_interleaved)
    begin
      return start ^ count;
    end
    return start + count;
  endfunction : sbsp_beat_addr

endpackage : sbsp_pkg

//--- src/sbsp_burst_ctr.sv
`timescale 1ns/100ps

module sbsp_burst_ctr
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  wire logic                          load,
  input  wire logic [sbsp_pkg::BURST_W-1:0]  start_bits,
  input  wire logic                          step,
  input  wire sbsp_pkg::sbsp_order_t         order,
  output wire logic [sbsp_pkg::BURST_W-1:0]  beat_bits
);

  logic [sbsp_pkg::BURST_W-1:0] start_reg;
  logic [sbsp_pkg::BURST_W-1:0] count_reg;

  // ----------------------------------------------------------------------
  // start bits and beat count
  // ----------------------------------------------------------------------
  // load wins over step, so a burst start always restarts the count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_reg <= sbsp_pkg::BEAT_RST;
      count_reg <= sbsp_pkg::BEAT_RST;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        start_reg <= start_bits;
        count_reg <= sbsp_pkg::BEAT_RST;
      end
      else if (step)
      begin
        count_reg <= count_reg + sbsp_pkg::BEAT_STEP;
      end
    end
  end

  // wraps inside the four-beat block, never carries into upper bits
  assign beat_bits = sbsp_pkg::sbsp_beat_addr(start_reg, count_reg,
                                              order);

endmodule : sbsp_burst_ctr

//--- src/sbsp_port.sv
`timescale 1ns/100ps

// Summary of operation
// - Every synchronous input is taken by registers on the rising edge of clk.
// - Address, write data, selects, strobes, advance and write controls are synchronous.
// - A two-bit counter loads the burst start and steps for the remaining beats.
// - Burst order high selects interleaved order, low selects linear order.
// - The controller address strobe, or the processor strobe with primary select low, starts a burst.
// - After the first beat the address steps only on advance, from the counter.
// - Address and selects are captured only on edges with a strobe active.
// - Output enable and sleep request act on the data drive without the clock.
// - First data of a burst after two cycles, each later beat after one more.
// - One shared data bus for reads and writes, 512k by 36 or 1m by 18.
// - The port works at bus rates up to 133 MHz.
module sbsp_port
#(
  parameter int ADDR_W = sbsp_pkg::ADDR_W_DFLT,
  parameter int DATA_W = sbsp_pkg::DATA_W_DFLT
)
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic                      burst_order,
  input  wire logic                      processor_addr_strobe_n,
  input  wire logic                      controller_addr_strobe_n,
  input  wire logic                      burst_advance_n,
  input  wire logic                      primary_select_n,
  input  wire logic                      depth_select_high,
  input  wire logic                      depth_select_low_n,
  input  wire logic [DATA_W/sbsp_pkg::LANE_W-1:0] byte_lane_write_n,
  input  wire logic                      byte_write_gate_n,
  input  wire logic                      all_bytes_write_n,
  input  wire logic                      output_enable_n,
  input  wire logic                      sleep_request,
  input  wire logic [DATA_W-1:0]         data_in,
  output logic      [DATA_W-1:0]         data_out,
  output logic                           data_oe_n
);

  localparam int LANES = DATA_W / sbsp_pkg::LANE_W;
  localparam int DEPTH = 2 ** ADDR_W;

  logic [DATA_W-1:0]            mem [DEPTH];
  logic [ADDR_W-1:0]            addr_reg;
  logic                         sel_reg;
  sbsp_pkg::sbsp_state_t        state_reg;
  sbsp_pkg::sbsp_state_t        state_next;
  logic [DATA_W-1:0]            data_out_reg;
  logic                         drive_reg;
  logic                         mode_meta_reg;
  logic                         mode_sync_reg;
  logic                         sleep_meta_reg;
  logic                         sleep_sync_reg;
  logic                         strobe_any;
  logic                         start_burst;
  logic                         step_burst;
  logic                         write_now;
  logic [LANES-1:0]             lane_mask;
  logic [sbsp_pkg::BURST_W-1:0] beat_bits;
  logic [ADDR_W-1:0]            beat_addr;
  sbsp_pkg::sbsp_order_t        order;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // all three selects must agree for the part to be chosen
  function automatic logic chip_chosen(
    input logic p_n,
    input logic hi,
    input logic lo_n
  );
    return ~p_n & hi & ~lo_n;
  endfunction : chip_chosen

  // global write overrides the gated per-lane strobes
  function automatic logic [LANES-1:0] lanes_written(
    input logic             all_n,
    input logic             gate_n,
    input logic [LANES-1:0] lane_n
  );
    if (!all_n)
    begin
      return {LANES{1'b1}};
    end
    if (!gate_n)
    begin
      return ~lane_n;
    end
    return {LANES{1'b0}};
  endfunction : lanes_written

  // ----------------------------------------------------------------------
  // pin synchronisers for the static order pin and sleep
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_meta_reg  <= sbsp_pkg::SYNC_RST;
      mode_sync_reg  <= sbsp_pkg::SYNC_RST;
      sleep_meta_reg <= sbsp_pkg::SYNC_RST;
      sleep_sync_reg <= sbsp_pkg::SYNC_RST;
    end
    else if (clk_en)
    begin
      mode_meta_reg  <= burst_order;
      mode_sync_reg  <= mode_meta_reg;
      sleep_meta_reg <= sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
    end
  end

  // high level gives interleaved order
  assign order = mode_sync_reg ? sbsp_pkg::sbsp_interleaved
                               : sbsp_pkg::sbsp_linear;

  // ----------------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------------
  // processor strobe starts no burst while the primary select is high, but
  // it still blocks advance, writes and the next drive of a running burst
  assign strobe_any  = ~processor_addr_strobe_n
                       | ~controller_addr_strobe_n;
  assign start_burst = ~sleep_sync_reg &
                       ((~processor_addr_strobe_n & ~primary_select_n) |
                        ~controller_addr_strobe_n);
  assign step_burst  = ~sleep_sync_reg & ~burst_advance_n & ~strobe_any
                       & (state_reg == sbsp_pkg::sbsp_burst);
  assign lane_mask   = lanes_written(all_bytes_write_n, byte_write_gate_n,
                                     byte_lane_write_n);
  // writes land on edges without a strobe, at the current beat address
  assign write_now   = ~sleep_sync_reg & ~strobe_any & sel_reg
                       & (state_reg == sbsp_pkg::sbsp_burst)
                       & (|lane_mask);

  // ----------------------------------------------------------------------
  // address and select capture
  // ----------------------------------------------------------------------
  // held between strobes; beats after the first never look at addr
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_reg <= '0;
      sel_reg  <= 1'b0;
    end
    else if (clk_en && start_burst)
    begin
      addr_reg <= addr;
      sel_reg  <= chip_chosen(primary_select_n, depth_select_high,
                              depth_select_low_n);
    end
  end

  // ----------------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------------
  sbsp_burst_ctr u_ctr
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .load       (start_burst),
    .start_bits (addr[sbsp_pkg::BURST_W-1:0]),
    .step       (step_burst),
    .order      (order),
    .beat_bits  (beat_bits)
  );

  // low bits come from the counter, upper bits from the capture
  assign beat_addr = {addr_reg[ADDR_W-1:sbsp_pkg::BURST_W],
                      beat_bits};

  // ----------------------------------------------------------------------
  // burst state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sbsp_pkg::sbsp_idle:
      begin
        if (start_burst)
        begin
          state_next = sbsp_pkg::sbsp_burst;
        end
      end
      sbsp_pkg::sbsp_burst:
      begin
        if (sleep_sync_reg)
        begin
          state_next = sbsp_pkg::sbsp_idle;
        end
      end
      default:
      begin
        state_next = sbsp_pkg::sbsp_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= sbsp_pkg::sbsp_idle;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // storage write, per nine-bit lane
  // ----------------------------------------------------------------------
  // storage has no reset: contents are undefined after power-up
  always_ff @(posedge clk)
  begin
    if (clk_en && write_now)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (lane_mask[i])
        begin
          mem[beat_addr][i*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W] <=
            data_in[i*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // one register after capture gives the first beat a two-cycle turn
  // and each later beat one cycle; costs a little clock-to-out
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_out_reg <= '0;
      drive_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      data_out_reg <= mem[beat_addr];
      drive_reg    <= sel_reg & ~sleep_sync_reg & ~strobe_any
                      & ~(|lane_mask)
                      & (state_reg == sbsp_pkg::sbsp_burst);
    end
  end

  assign data_out = data_out_reg;
  // enable and sleep bypass the clock so the bus frees at once
  assign data_oe_n = output_enable_n | sleep_request | ~drive_reg;

endmodule : sbsp_port

//--- dv/sbsp_host_bus.sv
`timescale 1ns/100ps

// ------------------------------------
// host end of the shared data bus
// ------------------------------------
module sbsp_host_bus
#(
  parameter int DW = 36
)
(
  input  wire logic          clk,
  input  wire logic          host_oe_n,
  input  wire logic [DW-1:0] host_d,
  input  wire logic          dev_oe_n,
  input  wire logic [DW-1:0] dev_d,
  output logic      [DW-1:0] bus
);
  logic [DW-1:0] last_reg = '0;
  // no keeper: a released bus shows the inverse of its last level
  always_comb
    bus = !host_oe_n ? host_d : (!dev_oe_n ? dev_d : ~last_reg);
  // last level seen, for the floating case
  always_ff @(posedge clk)
    last_reg <= bus;
endmodule : sbsp_host_bus

//--- dv/sbsp_port_asserts.sv
`timescale 1ns/100ps

// ------------------------------------
// drive timing and async pin checks
// ------------------------------------
module sbsp_port_asserts
#(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 36
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              processor_addr_strobe_n,
  input wire logic              controller_addr_strobe_n,
  input wire logic              burst_advance_n,
  input wire logic              primary_select_n,
  input wire logic              depth_select_high,
  input wire logic              depth_select_low_n,
  input wire logic              byte_write_gate_n,
  input wire logic              all_bytes_write_n,
  input wire logic              output_enable_n,
  input wire logic              sleep_request,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic quiet, sel, strb;
  // quiet: no strobe, no write, awake
  assign quiet = processor_addr_strobe_n & controller_addr_strobe_n
    & all_bytes_write_n & byte_write_gate_n & ~sleep_request;
  assign sel = ~primary_select_n & depth_select_high & ~depth_select_low_n;
  assign strb = clk_en & ~controller_addr_strobe_n;
  property p_oe; output_enable_n |-> data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("drive with oe off");
  property p_slp; sleep_request |-> data_oe_n; endproperty
  a_slp: assert property (p_slp) else $error("drive in sleep");
  property p_ctrl; strb |=> data_oe_n; endproperty
  a_ctrl: assert property (p_ctrl) else $error("drive after strobe");
  property p_proc; clk_en & ~processor_addr_strobe_n & ~primary_select_n
    |=> data_oe_n; endproperty
  a_proc: assert property (p_proc) else $error("drive after strobe");
  property p_wr; clk_en & ~all_bytes_write_n |=> data_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("drive after write");
  property p_first; strb & sel & ~sleep_request ##1 clk_en & quiet
    |=> data_oe_n == (output_enable_n | sleep_request); endproperty
  a_first: assert property (p_first) else $error("first beat late");
  property p_hold; strb ##1 clk_en & quiet & burst_advance_n
    ##1 clk_en & quiet |=> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("beat moved");
  property p_desel; strb & ~sel ##1 quiet |=> data_oe_n; endproperty
  a_desel: assert property (p_desel) else $error("deselected drive");
  property p_frz; ~clk_en |=> $stable(data_out); endproperty
  a_frz: assert property (p_frz) else $error("frozen data moved");
  c_read: cover property (strb & sel ##1 clk_en & quiet ##1 ~data_oe_n);
  c_frz: cover property (~clk_en ##1 clk_en);
  c_wr: cover property (clk_en & ~all_bytes_write_n);
endmodule : sbsp_port_asserts

bind sbsp_port sbsp_port_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .processor_addr_strobe_n(processor_addr_strobe_n),
  .controller_addr_strobe_n(controller_addr_strobe_n),
  .burst_advance_n(burst_advance_n), .primary_select_n(primary_select_n),
  .depth_select_high(depth_select_high),
  .depth_select_low_n(depth_select_low_n),
  .byte_write_gate_n(byte_write_gate_n),
  .all_bytes_write_n(all_bytes_write_n), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .data_out(data_out), .data_oe_n(data_oe_n));

//--- dv/tb.sv
`timescale 1ns/100ps

module tb;
  logic        clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, order = 1'h0;
  logic        proc_n = 1'h1, ctrl_n = 1'h1, adv_n = 1'h1, sel_n = 1'h0;
  logic        dhi = 1'h1, dlo_n = 1'h0, gate_n = 1'h1, all_n = 1'h1;
  logic        oe_n = 1'h0, sleep = 1'h0, hoe_n = 1'h1, doe_n;
  logic [3:0]  addr = 4'h0, lane_n = 4'hf;
  logic [35:0] hd = 36'h0, bus, dout;
  logic [35:0] mem [16];
  logic [31:0] r;
  int          n_fail = 0, checks = 0, cyc = 0;
  sbsp_port #(.ADDR_W(4), .DATA_W(36)) dut (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .addr(addr), .burst_order(order),
    .processor_addr_strobe_n(proc_n), .controller_addr_strobe_n(ctrl_n),
    .burst_advance_n(adv_n), .primary_select_n(sel_n),
    .depth_select_high(dhi), .depth_select_low_n(dlo_n),
    .byte_lane_write_n(lane_n), .byte_write_gate_n(gate_n),
    .all_bytes_write_n(all_n), .output_enable_n(oe_n),
    .sleep_request(sleep), .data_in(bus), .data_out(dout),
    .data_oe_n(doe_n));
  sbsp_host_bus #(.DW(36)) u_host (.clk(clk), .host_oe_n(hoe_n),
    .host_d(hd), .dev_oe_n(doe_n), .dev_d(dout), .bus(bus));
  // 100 MHz clock and a cycle ceiling against hangs
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      results();
    end
  end
  // ------------------------------------
  // expectations and compares
  // ------------------------------------
  function automatic logic [3:0] beat_a(input logic [3:0] a, input int c,
                                        input logic o);
    return {a[3:2], o ? a[1:0] ^ c[1:0] : a[1:0] + c[1:0]};
  endfunction : beat_a
  task automatic chk_d(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_d
  task automatic chk_f(input logic g, input logic e);
    chk_d({35'h0, g}, {35'h0, e});
  endtask : chk_f
  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ------------------------------------
  // bus cycles
  // ------------------------------------
  // order pin passes two flops, so it settles three edges ahead
  task automatic start(input logic [3:0] a, input logic o, input logic p);
    order <= o;
    repeat (3) @(posedge clk);
    addr <= a;
    if (p)
      proc_n <= 1'h0;
    else
      ctrl_n <= 1'h0;
    @(posedge clk);
    proc_n <= 1'h1;
    ctrl_n <= 1'h1;
  endtask : start
  task automatic wr(input logic [3:0] a, input logic o, input logic full);
    logic [31:0] w;
    logic [63:0] d;
    start(a, o, 1'h0);
    hoe_n <= 1'h0;
    adv_n <= 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      w = $urandom;
      d = {$urandom, $urandom};
      all_n <= full ? 1'h0 : w[4];
      gate_n <= w[5];
      lane_n <= w[3:0];
      hd <= d[35:0];
      @(posedge clk);
      for (int l = 0; l < 4; l++)
        if (full || !w[4] || (!w[5] && !w[l]))
          mem[beat_a(a, i, o)][9*l+:9] = d[9*l+:9];
    end
    all_n <= 1'h1;
    gate_n <= 1'h1;
    hoe_n <= 1'h1;
    adv_n <= 1'h1;
  endtask : wr
  // random stalls by advance and clock enable between beats
  task automatic rd(input logic [3:0] a, input logic o, input logic p);
    logic e, a_n, pe, pa;
    logic [31:0] q;
    int c;
    start(a, o, p);
    // later beats must come from the capture, not the live bus
    addr <= ~a;
    e = 1'h1;
    a_n = 1'h0;
    c = 0;
    adv_n <= a_n;
    for (int k = 0; k < 24 && c < 4; k++)
    begin
      @(posedge clk);
      pe = e;
      pa = a_n;
      q = $urandom;
      e = q[2:0] != 3'h0;
      a_n = q[4:3] == 2'h0;
      clk_en <= e;
      adv_n <= a_n;
      #1;
      if (pe)
      begin
        chk_d(dout, mem[beat_a(a, c, o)]);
        chk_f(doe_n, 1'h0);
        c = c + (pa ? 0 : 1);
      end
    end
    @(posedge clk);
    clk_en <= 1'h1;
    adv_n <= 1'h1;
  endtask : rd
  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial
  begin
    r = $urandom(32'h0132);
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    for (int b = 0; b < 4; b++)
      wr(4'(b * 4), b[0], 1'h1);
    for (int t = 0; t < 40; t++)
    begin
      r = $urandom;
      if (r[8])
        wr(r[3:0], r[4], 1'h0);
      rd(r[3:0], r[4], r[5]);
    end
    dhi <= 1'h0;
    start(4'h5, 1'h0, 1'h0);
    @(posedge clk);
    #1 chk_f(doe_n, 1'h1);
    @(posedge clk);
    dhi <= 1'h1;
    start(4'h6, 1'h1, 1'h0);
    @(posedge clk);
    #1 chk_f(doe_n, 1'h0);
    // drive stays set inside, so only the async path can free the bus
    @(posedge clk);
    oe_n <= 1'h1;
    #1 chk_f(doe_n, 1'h1);
    @(posedge clk);
    oe_n <= 1'h0;
    sleep <= 1'h1;
    #1 chk_f(doe_n, 1'h1);
    @(posedge clk);
    sleep <= 1'h0;
    #1 chk_f(doe_n, 1'h0);
    results();
  end
endmodule : tb
